// *** fbw_watchdog.sv ***
// Modbus communication watchdog core with its register access port
`timescale 1ns/1ps

module fbw_watchdog #(
    parameter int TICK_LEN = fbw_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // Register access from the protocol engine
    input  wire fbw_pkg::fbw_req_t req,
    input  wire logic             otherRequest,
    output fbw_pkg::fbw_rsp_t     rsp,
    // Watchdog outputs
    output logic [15:0]           stateReport,
    output logic                  timeoutPulse,
    output logic                  dropLinksOnExpiry
);
    // Tick counter is 16 bits wide, so longer ticks cannot be served
    if (TICK_LEN < 1 || TICK_LEN > 65536)
    begin : gen_tick_check
        $error("TICK_LEN out of range");
    end

    fbw_pkg::fbw_regs_t r_q;
    fbw_pkg::fbw_regs_t r_d;

    logic simpleMode;
    logic explicitOnly;
    logic active;
    logic trigger;
    logic isStatus;
    logic isStart;
    logic tick;

    assign simpleMode   = r_q.wdgCfg[fbw_pkg::CFG_SIMPLE_BIT];
    assign explicitOnly = r_q.wdgCfg[fbw_pkg::CFG_EXPLICIT_BIT];
    assign active       = (r_q.state == fbw_pkg::ST_RUNNING) || (r_q.state == fbw_pkg::ST_EXPIRED);
    assign isStatus     = req.valid && (req.addr == fbw_pkg::REG_STATE_REPORT);
    assign isStart      = req.valid && req.write && (req.addr == fbw_pkg::REG_COMMAND_ENTRY)
                          && (req.wdata == fbw_pkg::CMD_START);
    assign tick         = (r_q.tickCnt == 16'(TICK_LEN - 1));

    // Trigger selection
    always_comb
    begin
        if (explicitOnly)
            trigger = isStart;
        else if (isStatus)
            trigger = otherRequest || (!req.write && r_q.wdgCfg[fbw_pkg::CFG_STATUS_TRIG_BIT]);
        else
            trigger = (req.valid || otherRequest);
    end

    always_comb
    begin
        r_d = r_q;
        r_d.rsp.valid = 1'b0;
        r_d.rsp.exc = fbw_pkg::EXC_NONE;
        r_d.rsp.rdata = 16'h0000;
        r_d.expiredPulse = 1'b0;
        r_d.tickCnt = tick ? 16'h0000 : r_q.tickCnt + 16'h0001;

        // Countdown while running
        if (r_q.state == fbw_pkg::ST_RUNNING && tick)
        begin
            if (r_q.remain <= 16'h0001)
            begin
                r_d.state = fbw_pkg::ST_EXPIRED;
                r_d.expiredPulse = 1'b1;
                r_d.remain = 16'h0000;
            end
            else
                r_d.remain = r_q.remain - 16'h0001;
        end

        // Triggers restart a running or, in simple mode, expired watchdog
        if (trigger && r_q.state == fbw_pkg::ST_RUNNING)
        begin
            r_d.remain = r_q.timeout;
            r_d.tickCnt = 16'h0000;
            r_d.state = fbw_pkg::ST_RUNNING;
            r_d.expiredPulse = 1'b0;
        end
        else if (trigger && simpleMode && r_q.state == fbw_pkg::ST_EXPIRED)
        begin
            r_d.remain = r_q.timeout;
            r_d.tickCnt = 16'h0000;
            r_d.state = fbw_pkg::ST_RUNNING;
        end

        if (req.valid)
        begin
            r_d.rsp.valid = 1'b1;
            if (req.addr == fbw_pkg::REG_COMMAND_ENTRY)
            begin
                if (!req.write)
                    r_d.rsp.rdata = 16'h0000;
                else if (req.wdata == fbw_pkg::CMD_START)
                begin
                    if (r_q.state == fbw_pkg::ST_NO_PERIOD
                        || (!simpleMode && r_q.state == fbw_pkg::ST_EXPIRED))
                        r_d.rsp.exc = fbw_pkg::EXC_ILLEGAL_VALUE;
                    else
                    begin
                        r_d.state = fbw_pkg::ST_RUNNING;
                        r_d.remain = r_q.timeout;
                        r_d.tickCnt = 16'h0000;
                        r_d.expiredPulse = 1'b0;
                    end
                end
                else if (req.wdata == fbw_pkg::CMD_STOP)
                begin
                    if (simpleMode || r_q.state == fbw_pkg::ST_NO_PERIOD
                        || r_q.state == fbw_pkg::ST_EXPIRED)
                        r_d.rsp.exc = fbw_pkg::EXC_ILLEGAL_VALUE;
                    else
                        r_d.state = fbw_pkg::ST_STOPPED;
                end
                else if (req.wdata == fbw_pkg::CMD_RESET
                         && !simpleMode && r_q.state == fbw_pkg::ST_EXPIRED)
                    r_d.state = fbw_pkg::ST_STOPPED;
                else
                    r_d.rsp.exc = fbw_pkg::EXC_ILLEGAL_VALUE;
            end
            else if (req.addr == fbw_pkg::REG_TIMEOUT_PERIOD)
            begin
                if (!req.write)
                    r_d.rsp.rdata = r_q.timeout;
                else if (active)
                    r_d.rsp.exc = fbw_pkg::EXC_ILLEGAL_FUNC;
                else
                begin
                    r_d.timeout = req.wdata;
                    r_d.remain = req.wdata;
                    r_d.tickCnt = 16'h0000;
                    if (req.wdata == 16'h0000)
                        r_d.state = fbw_pkg::ST_NO_PERIOD;
                    else if (simpleMode)
                        r_d.state = fbw_pkg::ST_RUNNING;
                    else
                        r_d.state = fbw_pkg::ST_STOPPED;
                end
            end
            else if (req.addr == fbw_pkg::REG_STATE_REPORT)
            begin
                if (req.write)
                    r_d.rsp.exc = fbw_pkg::EXC_ILLEGAL_FUNC;
                else
                    r_d.rsp.rdata = stateReport;
            end
            else if (req.addr == fbw_pkg::REG_WDG_CONFIG)
            begin
                if (!req.write)
                    r_d.rsp.rdata = r_q.wdgCfg;
                else if (!simpleMode && active)
                    r_d.rsp.exc = fbw_pkg::EXC_ILLEGAL_FUNC;
                else
                begin
                    r_d.wdgCfg = req.wdata;
                    if (r_q.state != fbw_pkg::ST_NO_PERIOD)
                    begin
                        if (simpleMode && !req.wdata[fbw_pkg::CFG_SIMPLE_BIT])
                            r_d.state = fbw_pkg::ST_STOPPED;
                        else if (!simpleMode && req.wdata[fbw_pkg::CFG_SIMPLE_BIT])
                        begin
                            r_d.state = fbw_pkg::ST_RUNNING;
                            r_d.remain = r_q.timeout;
                            r_d.tickCnt = 16'h0000;
                        end
                    end
                end
            end
            else
                r_d.rsp.exc = fbw_pkg::EXC_ILLEGAL_FUNC;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            r_q.state <= fbw_pkg::ST_NO_PERIOD;
            r_q.timeout <= fbw_pkg::TIMEOUT_RESET;
            r_q.wdgCfg <= fbw_pkg::CFG_RESET;
            r_q.remain <= 16'h0000;
            r_q.tickCnt <= 16'h0000;
            r_q.rsp <= '0;
            r_q.expiredPulse <= 1'b0;
        end
        else
            r_q <= r_d;
    end

    // Status code from state
    always_comb
    begin
        case (r_q.state)
            fbw_pkg::ST_NO_PERIOD: stateReport = fbw_pkg::STAT_NO_PERIOD;
            fbw_pkg::ST_STOPPED:   stateReport = fbw_pkg::STAT_STOPPED;
            fbw_pkg::ST_RUNNING:   stateReport = fbw_pkg::STAT_RUNNING;
            default:               stateReport = fbw_pkg::STAT_EXPIRED;
        endcase
    end

    assign rsp = r_q.rsp;
    assign timeoutPulse = r_q.expiredPulse;
    // Pulse only on expiry, gated by the config choice
    assign dropLinksOnExpiry = r_q.expiredPulse && r_q.wdgCfg[fbw_pkg::CFG_DROP_LINKS_BIT];

    chk_expire_after_tick: assert property (@(posedge clock) disable iff (!resetn)
        (r_q.state == fbw_pkg::ST_RUNNING && tick && r_q.remain <= 16'h0001 && !trigger && !req.valid)
        |=> (r_q.state == fbw_pkg::ST_EXPIRED && timeoutPulse))
        else $error("watchdog did not expire");
    chk_start_refused: assert property (@(posedge clock) disable iff (!resetn)
        (isStart && r_q.state == fbw_pkg::ST_NO_PERIOD) |=> (rsp.valid && rsp.exc == fbw_pkg::EXC_ILLEGAL_VALUE))
        else $error("start not refused");
    chk_timeout_locked: assert property (@(posedge clock) disable iff (!resetn)
        (req.valid && req.write && req.addr == fbw_pkg::REG_TIMEOUT_PERIOD && active)
        |=> (rsp.exc == fbw_pkg::EXC_ILLEGAL_FUNC && $stable(r_q.timeout)))
        else $error("timeout write not refused");
    chk_status_code: assert property (@(posedge clock) disable iff (!resetn)
        (r_q.state == fbw_pkg::ST_RUNNING) |-> (stateReport == 16'h0001))
        else $error("wrong status code");
    chk_cmd_no_read: assert property (@(posedge clock) disable iff (!resetn)
        (req.valid && !req.write && req.addr == fbw_pkg::REG_COMMAND_ENTRY) |=> (rsp.rdata == 16'h0000))
        else $error("command register read back");
    chk_simple_no_stop: assert property (@(posedge clock) disable iff (!resetn)
        (simpleMode && r_q.state != fbw_pkg::ST_NO_PERIOD) |-> (r_q.state != fbw_pkg::ST_STOPPED))
        else $error("simple mode rests in stopped");
    chk_stop_simple: assert property (@(posedge clock) disable iff (!resetn)
        (simpleMode && req.valid && req.write && req.addr == fbw_pkg::REG_COMMAND_ENTRY
         && req.wdata == fbw_pkg::CMD_STOP) |=> (rsp.exc == fbw_pkg::EXC_ILLEGAL_VALUE))
        else $error("stop accepted in simple mode");
    chk_cfg_locked: assert property (@(posedge clock) disable iff (!resetn)
        (!simpleMode && active && req.valid && req.write && req.addr == fbw_pkg::REG_WDG_CONFIG)
        |=> $stable(r_q.wdgCfg))
        else $error("config changed while active");
    chk_reset_to_stop: assert property (@(posedge clock) disable iff (!resetn)
        (req.valid && req.write && req.addr == fbw_pkg::REG_COMMAND_ENTRY && req.wdata == fbw_pkg::CMD_RESET
         && !simpleMode && r_q.state == fbw_pkg::ST_EXPIRED)
        |=> (r_q.state == fbw_pkg::ST_STOPPED && rsp.exc == fbw_pkg::EXC_NONE))
        else $error("reset did not stop expired watchdog");
    chk_reset_refused: assert property (@(posedge clock) disable iff (!resetn)
        (req.valid && req.write && req.addr == fbw_pkg::REG_COMMAND_ENTRY && req.wdata == fbw_pkg::CMD_RESET
         && (simpleMode || r_q.state != fbw_pkg::ST_EXPIRED))
        |=> (rsp.exc == fbw_pkg::EXC_ILLEGAL_VALUE))
        else $error("reset not refused");
    chk_expiry_pulse: assert property (@(posedge clock) disable iff (!resetn)
        (r_q.state == fbw_pkg::ST_EXPIRED && $past(r_q.state) != fbw_pkg::ST_EXPIRED) |-> timeoutPulse)
        else $error("no pulse on entering expired");
    chk_drop_choice: assert property (@(posedge clock) disable iff (!resetn)
        (r_q.state == fbw_pkg::ST_EXPIRED && $past(r_q.state) != fbw_pkg::ST_EXPIRED)
        |-> (dropLinksOnExpiry == r_q.wdgCfg[fbw_pkg::CFG_DROP_LINKS_BIT]))
        else $error("link drop does not follow config");
    chk_other_trigger: assert property (@(posedge clock) disable iff (!resetn)
        (!explicitOnly && otherRequest && !req.valid && r_q.state == fbw_pkg::ST_RUNNING)
        |=> (r_q.state == fbw_pkg::ST_RUNNING && r_q.tickCnt == 16'h0000 && r_q.remain == r_q.timeout))
        else $error("other request did not restart timing");
    chk_explicit_only: assert property (@(posedge clock) disable iff (!resetn)
        (explicitOnly && otherRequest && !req.valid && r_q.state == fbw_pkg::ST_RUNNING && !tick)
        |=> (r_q.tickCnt != 16'h0000))
        else $error("other request triggered in explicit mode");
    chk_status_no_trig: assert property (@(posedge clock) disable iff (!resetn)
        (!r_q.wdgCfg[fbw_pkg::CFG_STATUS_TRIG_BIT] && isStatus && !otherRequest
         && r_q.state == fbw_pkg::ST_RUNNING && !tick)
        |=> (r_q.tickCnt != 16'h0000))
        else $error("status access restarted timing");
    chk_status_trig: assert property (@(posedge clock) disable iff (!resetn)
        (!explicitOnly && r_q.wdgCfg[fbw_pkg::CFG_STATUS_TRIG_BIT] && isStatus && !req.write
         && r_q.state == fbw_pkg::ST_RUNNING)
        |=> (r_q.state == fbw_pkg::ST_RUNNING && r_q.tickCnt == 16'h0000))
        else $error("status read did not restart timing");
    chk_period_zero: assert property (@(posedge clock) disable iff (!resetn)
        ((r_q.state == fbw_pkg::ST_NO_PERIOD) == (r_q.timeout == fbw_pkg::TIMEOUT_RESET)))
        else $error("unconfigured state and zero timeout disagree");
    chk_timeout_taken: assert property (@(posedge clock) disable iff (!resetn)
        (req.valid && req.write && req.addr == fbw_pkg::REG_TIMEOUT_PERIOD && !active)
        |=> (r_q.timeout == $past(req.wdata) && rsp.exc == fbw_pkg::EXC_NONE))
        else $error("timeout write not taken");
    chk_simple_restart: assert property (@(posedge clock) disable iff (!resetn)
        (trigger && simpleMode && r_q.state == fbw_pkg::ST_EXPIRED
         && !(req.valid && req.write && req.addr == fbw_pkg::REG_WDG_CONFIG))
        |=> (r_q.state == fbw_pkg::ST_RUNNING))
        else $error("simple mode did not restart");
    chk_mode_to_stop: assert property (@(posedge clock) disable iff (!resetn)
        (req.valid && req.write && req.addr == fbw_pkg::REG_WDG_CONFIG && simpleMode
         && !req.wdata[fbw_pkg::CFG_SIMPLE_BIT] && r_q.state != fbw_pkg::ST_NO_PERIOD)
        |=> (r_q.state == fbw_pkg::ST_STOPPED))
        else $error("leaving simple mode did not stop");
endmodule // fbw_watchdog

// *** fbw_pkg.sv ***
// Package for the fieldbus communication watchdog
package fbw_pkg;
    // Register indices in the special register space
    localparam logic [15:0] REG_COMMAND_ENTRY  = 16'hFA00;
    localparam logic [15:0] REG_TIMEOUT_PERIOD = 16'hFA01;
    localparam logic [15:0] REG_STATE_REPORT   = 16'hFA02;
    localparam logic [15:0] REG_WDG_CONFIG     = 16'hFA03;
    // Command codes
    localparam logic [15:0] CMD_START = 16'h5555;
    localparam logic [15:0] CMD_STOP  = 16'h55AA;
    localparam logic [15:0] CMD_RESET = 16'hAAAA;
    // Status codes
    localparam logic [15:0] STAT_NO_PERIOD = 16'hFFFF;
    localparam logic [15:0] STAT_STOPPED   = 16'h0000;
    localparam logic [15:0] STAT_RUNNING   = 16'h0001;
    localparam logic [15:0] STAT_EXPIRED   = 16'h0002;
    // Exception codes, zero meaning none
    localparam logic [7:0] EXC_NONE          = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FUNC  = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    // Config bit positions and reset value
    localparam int CFG_EXPLICIT_BIT = 0;
    localparam int CFG_STATUS_TRIG_BIT = 1;
    localparam int CFG_DROP_LINKS_BIT = 2;
    localparam int CFG_SIMPLE_BIT = 7;
    localparam logic [15:0] CFG_RESET = 16'h0004;
    localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
    // Tick timing
    localparam int CLOCK_HZ = 20_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLOCK_HZ / 1_000_000 * TICK_US;

    typedef enum logic [1:0] {
        ST_NO_PERIOD,
        ST_STOPPED,
        ST_RUNNING,
        ST_EXPIRED
    } fbw_state_t;

    // One register access from the protocol engine
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fbw_req_t;

    // Answer to one access
    typedef struct packed {
        logic        valid;
        logic [7:0]  exc;
        logic [15:0] rdata;
    } fbw_rsp_t;

    typedef struct packed {
        fbw_state_t  state;
        logic [15:0] timeout;
        logic [15:0] wdgCfg;
        logic [15:0] remain;
        logic [15:0] tickCnt;
        fbw_rsp_t    rsp;
        logic        expiredPulse;
    } fbw_regs_t;
endpackage

// *** fbw_master_model.sv ***
// Modbus master model issuing register accesses to the watchdog
`timescale 1ns/1ps

module fbw_master_model (
    // Clock
    input  wire logic              clock,
    // Requests towards the watchdog
    output fbw_pkg::fbw_req_t      req,
    output logic                   otherRequest,
    // Answers
    input  wire fbw_pkg::fbw_rsp_t rsp
);
    initial
    begin
        req          = '0;
        otherRequest = 1'h0;
    end

    // Released fields are inverted so a stale access never looks current
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                        output logic [7:0] exc, output logic [15:0] rdata, output logic ok);
        int i;
        ok    = 1'h0;
        exc   = 8'h00;
        rdata = 16'h0000;
        @(posedge clock);
        req <= '{valid: 1'h1, write: wr, addr: addr, wdata: data};
        @(posedge clock);
        req <= '{valid: 1'h0, write: ~wr, addr: ~addr, wdata: ~data};
        for (i = 0; i < 4 && !ok; i++)
        begin
            #1;
            if (rsp.valid === 1'h1)
            begin
                ok    = 1'h1;
                exc   = rsp.exc;
                rdata = rsp.rdata;
            end
            else
                @(posedge clock);
        end
    endtask

    // Any other service request, seen only as a trigger
    task automatic poke();
        @(posedge clock);
        otherRequest <= 1'h1;
        @(posedge clock);
        otherRequest <= 1'h0;
    endtask
endmodule // fbw_master_model

// *** testbench.sv ***
// Self-checking testbench for the communication watchdog
`timescale 1ns/1ps

module testbench;
    logic              clock;
    logic              resetn;
    fbw_pkg::fbw_req_t req;
    logic              otherRequest;
    fbw_pkg::fbw_rsp_t rsp;
    logic [15:0]       stateReport;
    logic              timeoutPulse;
    logic              dropLinksOnExpiry;
    int                n_fail;
    int                num_checks;
    int                nPulse;
    int                nDrop;

    initial clock = 1'h0;
    always #25 clock = ~clock;

    // Short tick keeps expiry within a few dozen cycles
    fbw_watchdog #(.TICK_LEN(4)) fbw_watchdog_i (
        .clock             (clock),
        .resetn            (resetn),
        .req               (req),
        .otherRequest      (otherRequest),
        .rsp               (rsp),
        .stateReport       (stateReport),
        .timeoutPulse      (timeoutPulse),
        .dropLinksOnExpiry (dropLinksOnExpiry)
    );

    fbw_master_model fbw_master_model_i (
        .clock        (clock),
        .req          (req),
        .otherRequest (otherRequest),
        .rsp          (rsp)
    );

    always @(posedge clock)
    begin
        if (timeoutPulse === 1'h1)
            nPulse++;
        if (dropLinksOnExpiry === 1'h1)
            nDrop++;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                       input logic [7:0] expExc, input logic [15:0] expData);
        logic [7:0]  exc;
        logic [15:0] rdata;
        logic        ok;
        fbw_master_model_i.xfer(wr, addr, data, exc, rdata, ok);
        if (!ok)
        begin
            n_fail++;
            $display("unexpected answer: expected 1, seen 0");
        end
        else
        begin
            chk("exception", {8'h00, expExc}, {8'h00, exc});
            chk("read data", expData, rdata);
        end
    endtask

    task automatic cmd(input logic [15:0] code, input logic [7:0] exc);
        acc(1'h1, fbw_pkg::REG_COMMAND_ENTRY, code, exc, 16'h0000);
    endtask

    task automatic tmo(input logic [15:0] val, input logic [7:0] exc);
        acc(1'h1, fbw_pkg::REG_TIMEOUT_PERIOD, val, exc, 16'h0000);
    endtask

    task automatic cfg(input logic [15:0] val, input logic [7:0] exc);
        acc(1'h1, fbw_pkg::REG_WDG_CONFIG, val, exc, 16'h0000);
    endtask

    task automatic st(input logic [15:0] exp);
        acc(1'h0, fbw_pkg::REG_STATE_REPORT, 16'h0000, fbw_pkg::EXC_NONE, exp);
        chk("state port", exp, stateReport);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Expiry must come within n cycles; a miss counts as a mismatch
    task automatic waitExp(input int n, input logic [15:0] expDrop);
        int i;
        int p0;
        p0 = nPulse;
        for (i = 0; i < n && nPulse == p0; i++)
            @(posedge clock);
        #1;
        if (nPulse == p0)
        begin
            n_fail++;
            $display("unexpected expiry: expected 1, seen 0");
        end
        else
            chk("drop links", expDrop, 16'(nDrop));
    endtask

    initial
    begin
        resetn = 1'h0;
        repeat (5) @(posedge clock);
        resetn <= 1'h1;
        st(fbw_pkg::STAT_NO_PERIOD);
        acc(1'h0, fbw_pkg::REG_TIMEOUT_PERIOD, 16'h0000, fbw_pkg::EXC_NONE, 16'h0000);
        cmd(fbw_pkg::CMD_START, fbw_pkg::EXC_ILLEGAL_VALUE);
        cmd(fbw_pkg::CMD_STOP, fbw_pkg::EXC_ILLEGAL_VALUE);
        cmd(fbw_pkg::CMD_RESET, fbw_pkg::EXC_ILLEGAL_VALUE);
        acc(1'h0, fbw_pkg::REG_COMMAND_ENTRY, 16'h0000, fbw_pkg::EXC_NONE, 16'h0000);
        acc(1'h0, 16'hFA10, 16'h0000, fbw_pkg::EXC_ILLEGAL_FUNC, 16'h0000);
        tmo(16'h0000, fbw_pkg::EXC_NONE);
        st(fbw_pkg::STAT_NO_PERIOD);
        tmo(16'h0004, fbw_pkg::EXC_NONE);
        st(fbw_pkg::STAT_STOPPED);
        cmd(fbw_pkg::CMD_STOP, fbw_pkg::EXC_NONE);
        cmd(fbw_pkg::CMD_STOP, fbw_pkg::EXC_NONE);
        cmd(fbw_pkg::CMD_START, fbw_pkg::EXC_NONE);
        st(fbw_pkg::STAT_RUNNING);
        tmo(16'h0009, fbw_pkg::EXC_ILLEGAL_FUNC);
        acc(1'h0, fbw_pkg::REG_TIMEOUT_PERIOD, 16'h0000, fbw_pkg::EXC_NONE, 16'h0004);
        cfg(16'h0084, fbw_pkg::EXC_ILLEGAL_FUNC);
        // Triggers closer than the timeout keep it alive
        repeat (6)
        begin
            idle(8);
            fbw_master_model_i.poke();
        end
        repeat (6) st(fbw_pkg::STAT_RUNNING);
        waitExp(14, 16'h0001);
        st(fbw_pkg::STAT_EXPIRED);
        cmd(fbw_pkg::CMD_START, fbw_pkg::EXC_ILLEGAL_VALUE);
        cmd(fbw_pkg::CMD_STOP, fbw_pkg::EXC_ILLEGAL_VALUE);
        cmd(fbw_pkg::CMD_RESET, fbw_pkg::EXC_NONE);
        st(fbw_pkg::STAT_STOPPED);
        cfg(16'h0084, fbw_pkg::EXC_NONE);
        st(fbw_pkg::STAT_RUNNING);
        cmd(fbw_pkg::CMD_STOP, fbw_pkg::EXC_ILLEGAL_VALUE);
        cmd(fbw_pkg::CMD_RESET, fbw_pkg::EXC_ILLEGAL_VALUE);
        cmd(16'h1234, fbw_pkg::EXC_ILLEGAL_VALUE);
        waitExp(30, 16'h0002);
        st(fbw_pkg::STAT_EXPIRED);
        cmd(fbw_pkg::CMD_START, fbw_pkg::EXC_NONE);
        st(fbw_pkg::STAT_RUNNING);
        cfg(16'h0004, fbw_pkg::EXC_NONE);
        st(fbw_pkg::STAT_STOPPED);
        // Explicit triggers only, and this expiry must not drop links
        cfg(16'h0001, fbw_pkg::EXC_NONE);
        cmd(fbw_pkg::CMD_START, fbw_pkg::EXC_NONE);
        // Other traffic no longer counts, so it must still run out
        repeat (3)
        begin
            idle(5);
            fbw_master_model_i.poke();
        end
        st(fbw_pkg::STAT_EXPIRED);
        chk("expiry count", 16'h0003, 16'(nPulse));
        chk("drop links", 16'h0002, 16'(nDrop));
        cmd(fbw_pkg::CMD_RESET, fbw_pkg::EXC_NONE);
        cfg(16'h0006, fbw_pkg::EXC_NONE);
        cmd(fbw_pkg::CMD_START, fbw_pkg::EXC_NONE);
        repeat (12) st(fbw_pkg::STAT_RUNNING);
        cmd(fbw_pkg::CMD_STOP, fbw_pkg::EXC_NONE);
        tmo(16'h0000, fbw_pkg::EXC_NONE);
        st(fbw_pkg::STAT_NO_PERIOD);
        summarize();
    end
endmodule // testbench
